// ### design/spm_pkg.sv
// Shared constants, types and helpers of the system prescaler and power modes
package spm_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Prescaler
   localparam int unsigned PRESC_W     = 13;
   localparam logic [12:0] PRESC_RST   = 13'h0000;
   localparam logic [12:0] PRESC_ONE   = 13'h0001;
   localparam logic [12:0] PRESC_FULL  = 13'h1fff;
   localparam int unsigned TAP_SEL_W   = 4;
   localparam logic [3:0]  TAP_SEL_MAX = 4'hc;      // Tap code for divide by 8192
   localparam int unsigned NUM_PERIPH  = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // System clock division codes and terminal counts
   localparam logic [2:0] SYSDIV_1     = 3'h0;
   localparam logic [2:0] SYSDIV_8     = 3'h1;
   localparam logic [2:0] SYSDIV_16    = 3'h2;
   localparam logic [2:0] SYSDIV_32    = 3'h3;
   localparam logic [2:0] SYSDIV_64    = 3'h4;
   localparam logic [5:0] SYSDIV_LIM_1  = 6'h00;
   localparam logic [5:0] SYSDIV_LIM_8  = 6'h07;
   localparam logic [5:0] SYSDIV_LIM_16 = 6'h0f;
   localparam logic [5:0] SYSDIV_LIM_32 = 6'h1f;
   localparam logic [5:0] SYSDIV_LIM_64 = 6'h3f;
   localparam logic [5:0] SYSDIV_CNT_RST = 6'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Standby exit wait
   localparam int unsigned WAIT_W      = 18;
   localparam logic [17:0] WAIT_RST    = 18'h00000;
   localparam logic [17:0] WAIT_ONE    = 18'h00001;
   localparam int unsigned WAIT_1K     = 1024;
   localparam int unsigned WAIT_128    = 128;
   localparam int unsigned WAIT_16     = 16;
   localparam logic [2:0]  WSEL_8K     = 3'h0;
   localparam logic [2:0]  WSEL_16K    = 3'h1;
   localparam logic [2:0]  WSEL_32K    = 3'h2;
   localparam logic [2:0]  WSEL_64K    = 3'h3;
   localparam logic [2:0]  WSEL_128K   = 3'h4;
   localparam logic [2:0]  WSEL_1K     = 3'h5;
   localparam logic [2:0]  WSEL_128    = 3'h6;
   localparam logic [2:0]  WSEL_16     = 3'h7;

   ////////////////////////////////////////////////////////////////////////////////
   // Operating modes
   typedef enum logic [4:0]
   {
      SPM_ACTIVE   = 5'h01,
      SPM_SLEEP    = 5'h02,
      SPM_STANDBY  = 5'h04,
      SPM_SUBSLEEP = 5'h08,
      SPM_WAKE     = 5'h10
   } spm_mode_type;

   // Low-bit mask of a tap: sel + 1 ones, clamped at the top tap
   function automatic logic [12:0] spm_tap_mask(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > TAP_SEL_MAX) ? TAP_SEL_MAX : sel;
      return PRESC_FULL >> (TAP_SEL_MAX - s);
   endfunction

   // Terminal count of the system clock divider
   function automatic logic [5:0] spm_sysdiv_lim(input logic [2:0] sel);
      logic [5:0] lim;
      case (sel)
         SYSDIV_1:  lim = SYSDIV_LIM_1;
         SYSDIV_8:  lim = SYSDIV_LIM_8;
         SYSDIV_16: lim = SYSDIV_LIM_16;
         SYSDIV_32: lim = SYSDIV_LIM_32;
         default:   lim = SYSDIV_LIM_64;
      endcase
      return lim;
   endfunction

endpackage

// ### design/spm_sysdiv.sv
// System clock divider: one-cycle enable pulse at the selected fraction of MCLK
`timescale 1ns/1ps
`default_nettype none
module spm_sysdiv
   import spm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [2:0] sel,
   output var  logic       en_q
);

   logic [5:0] cnt_q;
   logic [5:0] lim;

   assign lim = spm_sysdiv_lim(sel);

   ////////////////////////////////////////////////////////////////////////////////
   // Divider count, held at zero while the generator is stopped
   always_ff @(posedge clk)
   begin
      if (rst || !run)
      begin
         cnt_q <= SYSDIV_CNT_RST;
         en_q  <= 1'b0;
      end
      else if (cnt_q >= lim)
      begin
         cnt_q <= SYSDIV_CNT_RST;
         en_q  <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 6'h01;
         en_q  <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ### design/spm_tap.sv
// Per-peripheral tap: picks one prescaler bit and emits its divided tick
`timescale 1ns/1ps
`default_nettype none
module spm_tap
   import spm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [12:0] count,
   input  wire logic        adv,
   input  wire logic [3:0]  sel,
   input  wire logic        halt,
   output var  logic        tick_q
);

   logic [12:0] mask;

   assign mask = spm_tap_mask(sel);

   ////////////////////////////////////////////////////////////////////////////////
   // Tick when the chosen bit is about to toggle high to low
   always_ff @(posedge clk)
   begin
      if (rst)
         tick_q <= 1'b0;
      else
         tick_q <= adv && !halt && ((count & mask) == mask);
   end

endmodule
`default_nettype wire

// ### design/spm_top.sv
// System prescaler and power-mode control, with mode checks
`timescale 1ns/1ps
`default_nettype none
module spm_top
   import spm_pkg::*;
#(
   parameter int unsigned WAIT_8K   = 8192,
   parameter int unsigned WAIT_16K  = 16384,
   parameter int unsigned WAIT_32K  = 32768,
   parameter int unsigned WAIT_64K  = 65536,
   parameter int unsigned WAIT_128K = 131072
)
(
   input  wire logic                          MCLK,
   input  wire logic                          RST,
   input  wire logic                          SLEEP_EXEC,
   input  wire logic                          WAKE_IRQ,
   input  wire logic                          SOFTWARE_STANDBY_SELECT,
   input  wire logic                          SUBSLEEP_SELECT,
   input  wire logic [2:0]                    STANDBY_WAIT_SEL,
   input  wire logic [2:0]                    SYSCLK_DIV_SEL,
   input  wire logic [NUM_PERIPH-1:0]         MODULE_STANDBY,
   input  wire logic [NUM_PERIPH*TAP_SEL_W-1:0] PERIPH_DIV_SEL,
   output var  logic                          CPU_CLK_EN,
   output var  logic [NUM_PERIPH-1:0]         PERIPH_CLK_EN,
   output var  logic [NUM_PERIPH-1:0]         PERIPH_TICK,
   output var  logic                          PORT_HOLD,
   output var  logic                          OSC_RUN,
   output var  logic [4:0]                    MODE_STATE
);

   spm_mode_type mode_q;
   spm_mode_type mode_d;
   logic [12:0]  presc_q;
   logic [17:0]  wait_q;
   logic [17:0]  wait_load;
   logic         sys_en;
   logic         gen_run;
   logic         presc_run;
   logic         presc_adv;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock generator runs except while stopped in standby or subsleep
   assign gen_run   = (mode_q != SPM_STANDBY) && (mode_q != SPM_SUBSLEEP);
   assign presc_run = (mode_q == SPM_ACTIVE) || (mode_q == SPM_SLEEP);
   assign presc_adv = presc_run && sys_en;

   // System clock enable from the oscillator divider
   spm_sysdiv u_sysdiv
   (
      .clk  (MCLK),
      .rst  (RST),
      .run  (gen_run),
      .sel  (SYSCLK_DIV_SEL),
      .en_q (sys_en)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Prescaler count; internal only, no processor path
   always_ff @(posedge MCLK)
   begin
      if (RST)
         presc_q <= PRESC_RST;
      else if (!presc_run)
         presc_q <= PRESC_RST;
      else if (sys_en)
         presc_q <= presc_q + PRESC_ONE;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One tap selector per peripheral
   generate
      for (genvar i = 0; i < NUM_PERIPH; i++)
      begin : g_tap
         spm_tap u_tap
         (
            .clk    (MCLK),
            .rst    (RST),
            .count  (presc_q),
            .adv    (presc_adv),
            .sel    (PERIPH_DIV_SEL[i*TAP_SEL_W +: TAP_SEL_W]),
            .halt   (MODULE_STANDBY[i]),
            .tick_q (PERIPH_TICK[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Exit wait length from the standby wait select
   always_comb
   begin
      case (STANDBY_WAIT_SEL)
         WSEL_8K:   wait_load = 18'(WAIT_8K - 1);
         WSEL_16K:  wait_load = 18'(WAIT_16K - 1);
         WSEL_32K:  wait_load = 18'(WAIT_32K - 1);
         WSEL_64K:  wait_load = 18'(WAIT_64K - 1);
         WSEL_128K: wait_load = 18'(WAIT_128K - 1);
         WSEL_1K:   wait_load = 18'(WAIT_1K - 1);
         WSEL_128:  wait_load = 18'(WAIT_128 - 1);
         default:   wait_load = 18'(WAIT_16 - 1);
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mode sequencing
   always_comb
   begin
      mode_d = mode_q;
      case (mode_q)
         SPM_ACTIVE:
         begin
            if (SLEEP_EXEC)
            begin
               if (SOFTWARE_STANDBY_SELECT)
                  mode_d = SPM_STANDBY;
               else if (SUBSLEEP_SELECT)
                  mode_d = SPM_SUBSLEEP;
               else
                  mode_d = SPM_SLEEP;
            end
         end
         SPM_SLEEP:
         begin
            if (WAKE_IRQ)
               mode_d = SPM_ACTIVE;
         end
         SPM_STANDBY,
         SPM_SUBSLEEP:
         begin
            if (WAKE_IRQ)
               mode_d = SPM_WAKE;
         end
         SPM_WAKE:
         begin
            if (wait_q == WAIT_RST)
               mode_d = SPM_ACTIVE;
         end
         default:
            mode_d = SPM_ACTIVE;
      endcase
   end

   // Mode register
   always_ff @(posedge MCLK)
   begin
      if (RST)
         mode_q <= SPM_ACTIVE;
      else
         mode_q <= mode_d;
   end

   // Exit wait counter, loaded on the wake request
   always_ff @(posedge MCLK)
   begin
      if (RST)
         wait_q <= WAIT_RST;
      else if (mode_d == SPM_WAKE && mode_q != SPM_WAKE)
         wait_q <= wait_load;
      else if (mode_q == SPM_WAKE && wait_q != WAIT_RST)
         wait_q <= wait_q - WAIT_ONE;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registered CPU and peripheral clock enables
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         CPU_CLK_EN    <= 1'b0;
         PERIPH_CLK_EN <= '0;
      end
      else
      begin
         CPU_CLK_EN    <= sys_en && (mode_q == SPM_ACTIVE);
         PERIPH_CLK_EN <= (sys_en && presc_run) ? ~MODULE_STANDBY : '0;
      end
   end

   // Port hold, generator state and mode report
   always_ff @(posedge MCLK)
   begin
      if (RST)
      begin
         PORT_HOLD  <= 1'b0;
         OSC_RUN    <= 1'b0;
         MODE_STATE <= SPM_ACTIVE;
      end
      else
      begin
         PORT_HOLD  <= (mode_q == SPM_SUBSLEEP);
         OSC_RUN    <= gen_run;
         MODE_STATE <= mode_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_sleep_cmd;
      mode_q == SPM_ACTIVE && SLEEP_EXEC && !SOFTWARE_STANDBY_SELECT && !SUBSLEEP_SELECT;
   endsequence

   sequence s_standby_cmd;
      mode_q == SPM_ACTIVE && SLEEP_EXEC && SOFTWARE_STANDBY_SELECT;
   endsequence

   sequence s_wait16_start;
      $rose(mode_q == SPM_WAKE) && $past(STANDBY_WAIT_SEL) == WSEL_16;
   endsequence

   property p_count_step;
      @(posedge MCLK) disable iff (RST)
      presc_adv |=> presc_q == $past(presc_q) + PRESC_ONE;
   endproperty
   a_count_step: assert property (p_count_step) else $error("prescaler did not step");

   property p_reset_zero;
      @(posedge MCLK)
      RST |=> presc_q == PRESC_RST;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("prescaler not cleared");

   property p_stop_zero;
      @(posedge MCLK) disable iff (RST)
      (!gen_run && $past(!gen_run)) |-> presc_q == PRESC_RST && !sys_en;
   endproperty
   a_stop_zero: assert property (p_stop_zero) else $error("prescaler ran while stopped");

   property p_div8;
      @(posedge MCLK) disable iff (RST)
      (sys_en && gen_run && SYSCLK_DIV_SEL == SYSDIV_8)[*1] ##1
      (gen_run && SYSCLK_DIV_SEL == SYSDIV_8)[*8] |-> $past(sys_en, 8) && !$past(sys_en, 1);
   endproperty
   a_div8: assert property (p_div8) else $error("divide by 8 period wrong");

   property p_sleep_cpu;
      @(posedge MCLK) disable iff (RST)
      mode_q == SPM_SLEEP |=> !CPU_CLK_EN;
   endproperty
   a_sleep_cpu: assert property (p_sleep_cpu) else $error("CPU clocked in sleep");

   property p_standby_halt;
      @(posedge MCLK) disable iff (RST)
      mode_q == SPM_STANDBY |=> PERIPH_CLK_EN == '0 && !CPU_CLK_EN;
   endproperty
   a_standby_halt: assert property (p_standby_halt) else $error("clocks in standby");

   property p_port_hold;
      @(posedge MCLK) disable iff (RST)
      mode_q == SPM_SUBSLEEP |=> PORT_HOLD && PERIPH_CLK_EN == '0;
   endproperty
   a_port_hold: assert property (p_port_hold) else $error("ports not held");

   property p_mod_stby;
      @(posedge MCLK) disable iff (RST)
      (MODULE_STANDBY != '0) |=>
         ($past(MODULE_STANDBY) & (PERIPH_CLK_EN | PERIPH_TICK)) == '0;
   endproperty
   a_mod_stby: assert property (p_mod_stby) else $error("halted module clocked");

   property p_enter_sleep;
      @(posedge MCLK) disable iff (RST)
      s_sleep_cmd |=> mode_q == SPM_SLEEP;
   endproperty
   a_enter_sleep: assert property (p_enter_sleep) else $error("sleep not entered");

   property p_enter_standby;
      @(posedge MCLK) disable iff (RST)
      s_standby_cmd |=> mode_q == SPM_STANDBY;
   endproperty
   a_enter_standby: assert property (p_enter_standby) else $error("standby not entered");

   property p_wait16;
      @(posedge MCLK) disable iff (RST)
      s_wait16_start |-> (mode_q == SPM_WAKE)[*8] ##1 (mode_q == SPM_WAKE)[*8]
         ##1 mode_q == SPM_ACTIVE;
   endproperty
   a_wait16: assert property (p_wait16) else $error("16 state wait wrong");

endmodule
`default_nettype wire

// ### dv/spm_periph_model.sv
// CPU and peripheral side model: counts the enables and ticks it receives
`timescale 1ns/1ps
`default_nettype none
module spm_periph_model
   import spm_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  clr,
   input  wire logic                  cpu_en,
   input  wire logic [NUM_PERIPH-1:0] clk_en,
   input  wire logic [NUM_PERIPH-1:0] tick,
   output var  logic [15:0]           cpu_cnt_q,
   output var  logic [15:0]           en_cnt_q [NUM_PERIPH],
   output var  logic [15:0]           tick_cnt_q [NUM_PERIPH]
);
   ////////////////////////////////////////////////////////////////////////////////
   // CPU clock pulses seen
   always_ff @(posedge clk)
   begin
      cpu_cnt_q <= clr ? 16'h0000 : cpu_cnt_q + 16'(cpu_en);
   end

   // Peripheral enables and ticks seen, per module
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < NUM_PERIPH; i++)
      begin
         en_cnt_q[i]   <= clr ? 16'h0000 : en_cnt_q[i] + 16'(clk_en[i]);
         tick_cnt_q[i] <= clr ? 16'h0000 : tick_cnt_q[i] + 16'(tick[i]);
      end
   end
endmodule
`default_nettype wire

// ### dv/spm_top_tb_top.sv
// Self-checking testbench of the prescaler and power-mode block
`timescale 1ns/1ps
`default_nettype none
module spm_top_tb_top
   import spm_pkg::*;
;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        sleep_exec = 1'b0;
   logic        wake_irq = 1'b0;
   logic        stby_sel = 1'b0;
   logic        subsl = 1'b0;
   logic [2:0]  wsel = 3'h0;
   logic [2:0]  dsel = 3'h0;
   logic [7:0]  mstby = 8'h00;
   logic [31:0] pdsel = 32'h6fc43210;
   logic        clr = 1'b0;
   logic        cpu_en;
   logic [7:0]  pclk_en;
   logic [7:0]  ptick;
   logic        port_hold;
   logic        osc_run;
   logic [4:0]  mode;
   logic [15:0] cpu_cnt;
   logic [15:0] en_cnt [NUM_PERIPH];
   logic [15:0] tick_cnt [NUM_PERIPH];
   int          mismatches = 0;
   int          checks_done = 0;
   int          codes [8] = '{0, 1, 2, 3, 4, 12, 15, 6};
   int          divs [6] = '{1, 8, 16, 32, 64, 64};
   logic [2:0]  dsels [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   logic [2:0]  wsels [7] = '{3'h7, 3'h0, 3'h4, 3'h1, 3'h2, 3'h3, 3'h6};
   int          waits [7] = '{16, 64, 120, 80, 96, 112, 128};

   // Free-running oscillator clock
   always #4 mclk = ~mclk;

   spm_top #(.WAIT_8K(64), .WAIT_16K(80), .WAIT_32K(96), .WAIT_64K(112), .WAIT_128K(120)) dut
   (
      .MCLK(mclk), .RST(rst), .SLEEP_EXEC(sleep_exec), .WAKE_IRQ(wake_irq),
      .SOFTWARE_STANDBY_SELECT(stby_sel), .SUBSLEEP_SELECT(subsl), .STANDBY_WAIT_SEL(wsel),
      .SYSCLK_DIV_SEL(dsel), .MODULE_STANDBY(mstby), .PERIPH_DIV_SEL(pdsel),
      .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(pclk_en), .PERIPH_TICK(ptick),
      .PORT_HOLD(port_hold), .OSC_RUN(osc_run), .MODE_STATE(mode)
   );

   spm_periph_model model
   (
      .clk(mclk), .clr(clr), .cpu_en(cpu_en), .clk_en(pclk_en), .tick(ptick),
      .cpu_cnt_q(cpu_cnt), .en_cnt_q(en_cnt), .tick_cnt_q(tick_cnt)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Compare one value
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Wait n edges, then settle
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Clear the model counters and count for n cycles
   task automatic window(input int n);
      @(posedge mclk);
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
      cyc(n);
   endtask

   // Sleep instruction with the given mode selects
   task automatic sleep_cmd(input logic ss, input logic sub);
      @(posedge mclk);
      stby_sel   <= ss;
      subsl      <= sub;
      sleep_exec <= 1'b1;
      @(posedge mclk);
      sleep_exec <= 1'b0;
      cyc(4);
   endtask

   // Wake with a wait select; edges until active shown must be n + 2
   task automatic wake(input logic [2:0] sel, input int n);
      int k;
      @(posedge mclk);
      wsel     <= sel;
      wake_irq <= 1'b1;
      @(posedge mclk);
      wake_irq <= 1'b0;
      k = 1;
      #1;
      while (mode !== 5'h01 && k < 1200)
      begin
         @(posedge mclk);
         #1;
         k++;
      end
      chk(16'(k), 16'(n + 2));
   endtask

   // Hang guard
   initial
   begin
      #400000;
      mismatches++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      cyc(3);
      chk(16'(mode), 16'h0001);
      chk(16'({cpu_en, pclk_en}), 16'h0000);
      @(posedge mclk);
      rst <= 1'b0;
      cyc(3);
      chk(16'(osc_run), 16'h0001);
      // Each system clock division, CPU rate and first tap
      for (int s = 0; s < 6; s++)
      begin
         @(posedge mclk);
         dsel <= dsels[s];
         cyc(130);
         window(1024);
         chk(cpu_cnt, 16'(1024 / divs[s]));
         chk(en_cnt[0], 16'(1024 / divs[s]));
         chk(tick_cnt[0], 16'(512 / divs[s]));
      end
      // Independent taps, one module halted
      @(posedge mclk);
      dsel  <= 3'h0;
      mstby <= 8'h80;
      cyc(20);
      window(16384);
      for (int i = 0; i < 7; i++)
      begin
         chk(tick_cnt[i], 16'(16384 >> ((codes[i] > 12 ? 12 : codes[i]) + 1)));
         chk(en_cnt[i], 16'h4000);
      end
      chk(tick_cnt[7], 16'h0000);
      chk(en_cnt[7], 16'h0000);
      @(posedge mclk);
      mstby <= 8'h00;
      // Sleep
      sleep_cmd(1'b0, 1'b0);
      chk(16'(mode), 16'h0002);
      window(256);
      chk(cpu_cnt, 16'h0000);
      chk(en_cnt[0], 16'h0100);
      wake(3'h7, 0);
      // Standby with several exit waits
      for (int w = 0; w < 7; w++)
      begin
         sleep_cmd(1'b1, 1'b0);
         chk(16'(mode), 16'h0004);
         chk(16'(osc_run), 16'h0000);
         window(64);
         chk(cpu_cnt + en_cnt[0] + tick_cnt[0], 16'h0000);
         wake(wsels[w], waits[w]);
      end
      // Subsleep
      sleep_cmd(1'b0, 1'b1);
      chk(16'(mode), 16'h0008);
      chk(16'({port_hold, osc_run}), 16'h0002);
      window(64);
      chk(cpu_cnt + en_cnt[0] + tick_cnt[0], 16'h0000);
      wake(3'h5, 1024);
      chk(16'(port_hold), 16'h0000);
      give_verdict();
   end
endmodule
`default_nettype wire
